/* core/dccr_regs.sv */
// channel load, mode, power and soft reset registers
`timescale 1ns/10ps
module dccr_regs
    import dccr_pkg::*;
(
    input  wire logic                          clock,   // 100 MHz clock
    input  wire logic                          rst_n,   // async, active low
    input  wire dccr_req_t                     req,     // register access
    input  wire logic                          txn_done, // frame finished
    input  wire logic [NUM_CH-1:0]             latch_transparent_select, // cfg
    input  wire logic                overcurrent_response_select, // 1 = host
    input  wire logic [NUM_CH-1:0]             overcurrent_flag, // async
    input  wire logic [NUM_CH-1:0][DATA_W-1:0] chan_data, // data registers
    output logic      [REG_W-1:0]              rdata,   // read data
    output logic                               rvalid,  // read data valid
    output logic      [NUM_CH-1:0][DATA_W-1:0] dac_code, // latched codes
    output logic      [NUM_CH-1:0]             output_kind_select, // mode
    output logic      [NUM_CH-1:0]             output_power_on, // power
    output dccr_cmd_t                          cmd      // command strobes
);

    ////////////////////////////////////////////////////////////////////////
    // access decode

    logic              wr_load;
    logic              wr_mode;
    logic              wr_srst;
    logic [NUM_CH-1:0] load_req;
    logic              clr_req;
    logic              rst_req;

    always_comb
    begin
        wr_load  = req.wr && (req.addr == ADDR_LOAD);
        wr_mode  = req.wr && (req.addr == ADDR_MODE);
        wr_srst  = req.wr && (req.addr == ADDR_SRST);
        // a zero bit requests nothing
        load_req = wr_load ? req.wdata[LOAD_LSB +: NUM_CH] : '0;
        clr_req  = wr_srst && req.wdata[CLEAR_BIT];
        rst_req  = wr_srst && req.wdata[SRST_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // overcurrent synchroniser

    logic [NUM_CH-1:0] ovc_s1_r;
    logic [NUM_CH-1:0] ovc_s2_r;
    logic [NUM_CH-1:0] ovc_s3_r;
    logic [NUM_CH-1:0] ovc_rise;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovc_s1_r <= '0;
            ovc_s2_r <= '0;
            ovc_s3_r <= '0;
        end
        else
        begin
            ovc_s1_r <= overcurrent_flag;
            ovc_s2_r <= ovc_s1_r;
            ovc_s3_r <= ovc_s2_r;
        end
    end

    assign ovc_rise = ovc_s2_r & ~ovc_s3_r;

    ////////////////////////////////////////////////////////////////////////
    // pending commands, mode and power

    logic [NUM_CH-1:0] load_pend_r;
    logic [NUM_CH-1:0] load_pend_nxt;
    logic              clr_pend_r;
    logic              clr_pend_nxt;
    logic              rst_pend_r;
    logic              rst_pend_nxt;
    logic [NUM_CH-1:0] kind_r;
    logic [NUM_CH-1:0] kind_nxt;
    logic [NUM_CH-1:0] power_r;
    logic [NUM_CH-1:0] power_nxt;
    dccr_cmd_t         cmd_r;
    dccr_cmd_t         cmd_nxt;
    logic [NUM_CH-1:0] load_now;
    logic              clr_exec;
    logic              rst_exec;
    logic              clear_now;

    always_comb
    begin
        // commands act once, when the frame that carried them ends
        load_now  = (load_pend_r | load_req) & {NUM_CH{txn_done}};
        clr_exec  = txn_done && (clr_pend_r || clr_req);
        rst_exec  = txn_done && (rst_pend_r || rst_req);
        clear_now = clr_exec || rst_exec;

        // a request in the completing cycle acts now and is not kept
        load_pend_nxt = txn_done ? '0 : (load_pend_r | load_req);
        clr_pend_nxt  = txn_done ? 1'b0 : (clr_pend_r || clr_req);
        rst_pend_nxt  = txn_done ? 1'b0 : (rst_pend_r || rst_req);
        if (clear_now)
            load_pend_nxt = '0;

        kind_nxt  = kind_r;
        power_nxt = power_r;
        if (wr_mode)
        begin
            kind_nxt  = req.wdata[KIND_LSB +: NUM_CH];
            power_nxt = req.wdata[POWER_LSB +: NUM_CH];
        end
        // overcurrent wins over a host rewrite in the same cycle
        if (overcurrent_response_select)
            power_nxt = power_nxt & ~ovc_rise;
        if (rst_exec)
        begin
            kind_nxt  = KIND_RST;
            power_nxt = POWER_RST;
        end

        cmd_nxt.data_clear = clr_exec;
        cmd_nxt.full_reset = rst_exec;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_pend_r <= '0;
            clr_pend_r  <= 1'b0;
            rst_pend_r  <= 1'b0;
            kind_r      <= KIND_RST;
            power_r     <= POWER_RST;
            cmd_r       <= '0;
        end
        else
        begin
            load_pend_r <= load_pend_nxt;
            clr_pend_r  <= clr_pend_nxt;
            rst_pend_r  <= rst_pend_nxt;
            kind_r      <= kind_nxt;
            power_r     <= power_nxt;
            cmd_r       <= cmd_nxt;
        end
    end

    assign output_kind_select = kind_r;
    assign output_power_on    = power_r;
    assign cmd                = cmd_r;

    ////////////////////////////////////////////////////////////////////////
    // dac latches

    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_latch
        dccr_latch #(
            .WIDTH       (DATA_W)
        ) u_latch (
            .clock       (clock),
            .rst_n       (rst_n),
            .transparent (latch_transparent_select[ch]),
            .load        (load_now[ch]),
            .clear       (clear_now),
            .data_in     (chan_data[ch]),
            .code_out    (dac_code[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // read back

    logic [REG_W-1:0] rdata_r;
    logic [REG_W-1:0] rdata_nxt;
    logic             rvalid_r;
    logic             rvalid_nxt;

    always_comb
    begin
        rvalid_nxt = req.rd;
        rdata_nxt  = RDATA_RST;
        // load and soft reset registers read all zero
        if (req.rd && req.addr == ADDR_MODE)
        begin
            rdata_nxt[KIND_LSB +: NUM_CH]  = kind_r;
            rdata_nxt[POWER_LSB +: NUM_CH] = power_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r  <= RDATA_RST;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign rdata  = rdata_r;
    assign rvalid = rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_load_strobe;
        @(posedge clock) disable iff (!rst_n)
        (txn_done && load_pend_r[0] && !latch_transparent_select[0]
            && !clear_now)
        |=> (dac_code[0] == $past(chan_data[0]));
    endproperty
    a_load_strobe: assert property (p_load_strobe)
        else $error("load strobe did not move channel data to dac");

    property p_load_selfclear;
        @(posedge clock) disable iff (!rst_n)
        txn_done |=> (load_pend_r == '0)
            ##1 (load_pend_r == '0 || $past(wr_load));
    endproperty
    a_load_selfclear: assert property (p_load_selfclear)
        else $error("load bits stayed set after transaction end");

    property p_kind_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_mode && !rst_exec)
        |=> (output_kind_select == $past(req.wdata[KIND_LSB +: NUM_CH]));
    endproperty
    a_kind_write: assert property (p_kind_write)
        else $error("mode bits not taken from write");

    property p_power_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_mode && !rst_exec && ovc_rise == '0)
        |=> (output_power_on == $past(req.wdata[POWER_LSB +: NUM_CH]));
    endproperty
    a_power_write: assert property (p_power_write)
        else $error("power bits not taken from write");

    property p_data_clear;
        @(posedge clock) disable iff (!rst_n)
        (clr_exec && !rst_exec && !wr_mode)
        |=> (cmd.data_clear && dac_code == '0
            && output_kind_select == $past(output_kind_select));
    endproperty
    a_data_clear: assert property (p_data_clear)
        else $error("data clear wrong or touched mode bits");

    property p_full_reset;
        @(posedge clock) disable iff (!rst_n)
        rst_exec |=> (cmd.full_reset && output_kind_select == KIND_RST
            && output_power_on == POWER_RST && dac_code == '0);
    endproperty
    a_full_reset: assert property (p_full_reset)
        else $error("full soft reset left state behind");

    property p_cmd_selfclear;
        @(posedge clock) disable iff (!rst_n)
        (txn_done && !req.wr) |=> (!clr_pend_r && !rst_pend_r)
            ##1 !cmd.data_clear && !cmd.full_reset;
    endproperty
    a_cmd_selfclear: assert property (p_cmd_selfclear)
        else $error("command bit outlived its transaction");

    property p_transparent;
        @(posedge clock) disable iff (!rst_n)
        (latch_transparent_select[1] && !clear_now)
        |=> (dac_code[1] == $past(chan_data[1]));
    endproperty
    a_transparent: assert property (p_transparent)
        else $error("transparent latch did not follow data");

    property p_ovc_power;
        @(posedge clock) disable iff (!rst_n)
        (overcurrent_response_select && ovc_rise != '0)
        |=> ((output_power_on & $past(ovc_rise)) == '0);
    endproperty
    a_ovc_power: assert property (p_ovc_power)
        else $error("overcurrent left channel powered");

    property p_read_zero;
        @(posedge clock) disable iff (!rst_n)
        (req.rd && (req.addr == ADDR_LOAD || req.addr == ADDR_SRST))
        |=> (rvalid && rdata == '0);
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("command register read back nonzero");
endmodule

/* pkg/dccr_pkg.sv */
// constants and carriers of the channel control register group
package dccr_pkg;

    localparam int unsigned NUM_CH  = 4;
    localparam int unsigned DATA_W  = 12;
    localparam int unsigned REG_W   = 16;
    localparam int unsigned ADDR_W  = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_LOAD = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_SRST = 8'h06;

    // field positions
    localparam int unsigned LOAD_LSB  = 12;
    localparam int unsigned KIND_LSB  = 12;
    localparam int unsigned POWER_LSB = 8;
    localparam int unsigned CLEAR_BIT = 12;
    localparam int unsigned SRST_BIT  = 8;

    // values after reset
    localparam logic [NUM_CH-1:0] KIND_RST  = 4'h0;
    localparam logic [NUM_CH-1:0] POWER_RST = 4'h0;
    localparam logic [DATA_W-1:0] CODE_RST  = 12'h000;
    localparam logic [REG_W-1:0]  RDATA_RST = 16'h0000;

    // one register access from the serial frame decoder
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } dccr_req_t;

    // one-cycle command strobes towards the rest of the register file
    typedef struct packed {
        logic data_clear;
        logic full_reset;
    } dccr_cmd_t;

endpackage

/* core/dccr_latch.sv */
// one channel's dac input latch
`timescale 1ns/10ps
module dccr_latch
    import dccr_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W
)
(
    input  wire logic             clock,       // system clock
    input  wire logic             rst_n,       // async reset, active low
    input  wire logic             transparent, // latch follows data
    input  wire logic             load,        // one-cycle load strobe
    input  wire logic             clear,       // one-cycle clear strobe
    input  wire logic [WIDTH-1:0] data_in,     // channel data register
    output logic      [WIDTH-1:0] code_out     // code held for the dac
);

    logic [WIDTH-1:0] code_r;
    logic [WIDTH-1:0] code_nxt;

    always_comb
    begin
        code_nxt = code_r;
        if (clear)
            code_nxt = '0;
        else if (transparent || load)
            code_nxt = data_in;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            code_r <= '0;
        else
            code_r <= code_nxt;
    end

    assign code_out = code_r;

endmodule

/* tb/dccr_host.sv */
// host model issuing register accesses and frame ends
`timescale 1ns/10ps
module dccr_host
    import dccr_pkg::*;
(
    input  wire logic clock,   // system clock
    output dccr_req_t req,     // register access
    output logic      txn_done // frame finished
);
    initial
    begin
        req = '0;
        txn_done = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one access held for one rising edge
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [REG_W-1:0] d);
        @(negedge clock);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clock);
        req = '0;
    endtask

    // end of serial transaction
    task automatic done();
        @(negedge clock);
        txn_done = 1'b1;
        @(negedge clock);
        txn_done = 1'b0;
    endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench of the channel control registers
`timescale 1ns/10ps
module tb_top;
    import dccr_pkg::*;

    logic                          clock;
    logic                          rst_n;
    dccr_req_t                     req;
    logic                          txn_done;
    logic [NUM_CH-1:0]             sel;
    logic                          ovc_host;
    logic [NUM_CH-1:0]             ovc;
    logic [NUM_CH-1:0][DATA_W-1:0] cdata;
    logic [REG_W-1:0]              rdata;
    logic                          rvalid;
    logic [NUM_CH-1:0][DATA_W-1:0] dac;
    logic [NUM_CH-1:0]             kind;
    logic [NUM_CH-1:0]             pwr;
    dccr_cmd_t                     cmd;
    int                            n_errors;
    int                            total_checks;

    dccr_host u_host (.clock(clock), .req(req), .txn_done(txn_done));

    dccr_regs u_dut (
        .clock                      (clock),
        .rst_n                      (rst_n),
        .req                        (req),
        .txn_done                   (txn_done),
        .latch_transparent_select   (sel),
        .overcurrent_response_select(ovc_host),
        .overcurrent_flag           (ovc),
        .chan_data                  (cdata),
        .rdata                      (rdata),
        .rvalid                     (rvalid),
        .dac_code                   (dac),
        .output_kind_select         (kind),
        .output_power_on            (pwr),
        .cmd                        (cmd)
    );

    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        u_host.acc(1'b0, a, 16'h0000);
        chk("rvalid", rvalid, 1'b1);
        chk("rdata", rdata, e);
    endtask

    task automatic summarize();
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_load();
        cdata = {12'h333, 12'h222, 12'h111, 12'h0AB};
        u_host.acc(1'b1, ADDR_LOAD, 16'h9000);
        chk("dac early", dac, '0);
        u_host.done();
        chk("dac load", dac, {12'h333, 24'h0, 12'h0AB});
        cdata = {12'h777, 12'h666, 12'h555, 12'h444};
        u_host.done();
        chk("dac kept", dac, {12'h333, 24'h0, 12'h0AB});
        rchk(ADDR_LOAD, 16'h0000);
    endtask

    task automatic t_transp();
        sel = 4'h2;
        cdata[1] = 12'h5A5;
        repeat (2) @(negedge clock);
        chk("dac ch1", dac[1], 12'h5A5);
        sel = 4'h0;
        cdata[1] = 12'h111;
        repeat (2) @(negedge clock);
        chk("dac held", dac[1], 12'h5A5);
    endtask

    task automatic t_mode(input logic [15:0] d);
        u_host.acc(1'b1, ADDR_MODE, d);
        chk("kind", kind, d[15:12]);
        chk("power", pwr, d[11:8]);
        rchk(ADDR_MODE, {d[15:8], 8'h00});
    endtask

    task automatic t_clear();
        u_host.acc(1'b1, ADDR_SRST, 16'h1000);
        chk("cmd early", cmd, 2'b00);
        u_host.done();
        chk("cmd clear", cmd, 2'b10);
        chk("dac clr", dac, '0);
        chk("kind kept", kind, 4'h5);
        chk("power kept", pwr, 4'hA);
        @(negedge clock);
        chk("cmd end", cmd, 2'b00);
        rchk(ADDR_SRST, 16'h0000);
    endtask

    task automatic t_zero();
        u_host.acc(1'b1, ADDR_SRST, 16'h0000);
        u_host.acc(1'b1, ADDR_LOAD, 16'h0000);
        u_host.acc(1'b1, 8'h20, 16'hFFFF);
        u_host.done();
        chk("cmd zero", cmd, 2'b00);
        chk("dac zero", dac, '0);
        chk("kind unm", kind, 4'h5);
        rchk(8'h20, 16'h0000);
    endtask

    task automatic t_full();
        u_host.acc(1'b1, ADDR_LOAD, 16'h1000);
        u_host.done();
        u_host.acc(1'b1, ADDR_SRST, 16'h0100);
        u_host.done();
        chk("cmd full", cmd, 2'b01);
        chk("kind rst", kind, 4'h0);
        chk("power rst", pwr, 4'h0);
        chk("dac rst", dac, '0);
        @(negedge clock);
        chk("cmd end", cmd, 2'b00);
    endtask

    task automatic t_ovc(input logic host);
        int i;
        ovc_host = host;
        u_host.acc(1'b1, ADDR_MODE, 16'h0F00);
        ovc = 4'h4;
        for (i = 0; i < 10 && pwr[2] !== 1'b0; i++)
            @(negedge clock);
        if (host && i == 10)
        begin
            n_errors++;
            $display("Error power ovc timeout expected 3 seen 10");
        end
        chk("power ovc", pwr, host ? 4'hB : 4'hF);
        ovc = 4'h0;
        repeat (3) @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        sel = 4'h0;
        ovc_host = 1'b0;
        ovc = 4'h0;
        cdata = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        chk("reset", {kind, pwr, cmd, dac}, '0);
        rchk(ADDR_MODE, 16'h0000);
        t_load();
        t_transp();
        t_mode(16'hA5FF);
        t_mode(16'h5A00);
        t_clear();
        t_zero();
        t_full();
        t_ovc(1'b1);
        t_ovc(1'b0);
        summarize();
    end
endmodule
